// ==== pkg/adc_ctrl_cfg.svh ====
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// Register byte addresses on the AXI4-Lite bus.
`define OFS_CONTROL     8'h00
`define OFS_CONFIG      8'h04
`define OFS_CHANNEL     8'h08
`define OFS_PAIR_CFG    8'h0c
`define OFS_RESULT_HI   8'h10
`define OFS_RESULT_LO   8'h14
`define OFS_IRQ_ENABLE  8'h18

// Control register fields.
`define CTL_ENABLE_BIT  7
`define CTL_LP_TRACK_BIT 6
`define CTL_DONE_BIT    5
`define CTL_BUSY_BIT    4
`define CTL_SRC_HI_BIT  3
`define CTL_SRC_LO_BIT  2
`define CTL_LJUST_BIT   0

// Configuration register fields and reset values.
`define CFG_DIV_MSB     7
`define CFG_DIV_LSB     3
`define CFG_GAIN_MSB    2
`define CFG_RESET       8'hf8
`define PAIR_RESET      4'h0
`define CHANNEL_RESET   4'h0
`define TEMP_SENSOR_BIT 3

// Start source codes.
`define SRC_BUSY_WRITE  2'b00
`define SRC_TIMER3      2'b01
`define SRC_STROBE      2'b10
`define SRC_TIMER2      2'b11

// Converter figures.
`define RESULT_BITS     10
`define SAR_MIDSCALE    10'h200
`define TRACK_SAR_CLKS  2'd3
`define CONV_SAR_CLKS   4'd10
`define CLK_PERIOD_NS   10
`define MAX_RATE_KSPS   100
`define MIN_CONV_PERIOD_NS (1000000 / `MAX_RATE_KSPS)
`define MIN_CONV_CYCLES \
  ((`MIN_CONV_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ==== pkg/adc_types_pkg.sv ====
package adc_types_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_TRACK  = 2'b01,
    ST_CONV   = 2'b11,
    ST_FINISH = 2'b10
  } sar_state_e;

  typedef enum logic [2:0] {
    GAIN_X1   = 3'h0,
    GAIN_X2   = 3'h1,
    GAIN_X4   = 3'h2,
    GAIN_X8   = 3'h3,
    GAIN_X16  = 3'h4,
    GAIN_HALF = 3'h5
  } gain_e;

endpackage

// ==== pkg/sar_if.sv ====
`timescale 1ns/100ps

interface sar_if;
  logic       enable;
  logic       start;
  logic       skip_track;
  logic [4:0] div;
  logic       comp_hi;
  logic       busy;
  logic       tracking;
  logic       done;
  logic [9:0] code;

  modport engine (
    input  enable, start, skip_track, div, comp_hi,
    output busy, tracking, done, code
  );
  modport ctrl (
    output enable, start, skip_track, div, comp_hi,
    input  busy, tracking, done, code
  );
endinterface

// ==== rtl/sar_engine.sv ====
`timescale 1ns/100ps
`include "adc_ctrl_cfg.svh"

module sar_engine (
  input wire logic aclk,
  input wire logic aresetn,
  sar_if.engine    sar
);

  adc_types_pkg::sar_state_e state_ff;
  logic [4:0] div_lat_ff;
  logic [4:0] div_cnt_ff;
  logic [1:0] trk_cnt_ff;
  logic [3:0] bit_ff;
  logic [9:0] code_ff;
  logic       tick;

  // One SAR clock lasts div + 1 system clocks.
  assign tick = (div_cnt_ff == div_lat_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff == adc_types_pkg::ST_IDLE || tick) begin
      div_cnt_ff <= 5'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= adc_types_pkg::ST_IDLE;
      div_lat_ff <= 5'h1f;
      trk_cnt_ff <= 2'h0;
      bit_ff     <= 4'h0;
      code_ff    <= 10'h000;
    end else if (!sar.enable) begin
      state_ff <= adc_types_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        adc_types_pkg::ST_IDLE: begin
          if (sar.start) begin
            div_lat_ff <= sar.div;
            trk_cnt_ff <= 2'h0;
            if (sar.skip_track) begin
              state_ff <= adc_types_pkg::ST_CONV;
              code_ff  <= `SAR_MIDSCALE;
              bit_ff   <= 4'h9;
            end else begin
              state_ff <= adc_types_pkg::ST_TRACK;
            end
          end
        end
        adc_types_pkg::ST_TRACK: begin
          if (tick) begin
            if (trk_cnt_ff == `TRACK_SAR_CLKS - 2'd1) begin
              state_ff <= adc_types_pkg::ST_CONV;
              code_ff  <= `SAR_MIDSCALE;
              bit_ff   <= 4'h9;
            end else begin
              trk_cnt_ff <= trk_cnt_ff + 2'h1;
            end
          end
        end
        adc_types_pkg::ST_CONV: begin
          if (tick) begin
            // Keep the trial bit only if the input is above the trial level.
            code_ff[bit_ff] <= sar.comp_hi;
            if (bit_ff == 4'h0) begin
              state_ff <= adc_types_pkg::ST_FINISH;
            end else begin
              code_ff[bit_ff - 4'h1] <= 1'b1;
              bit_ff <= bit_ff - 4'h1;
            end
          end
        end
        default: begin
          state_ff <= adc_types_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign sar.busy     = (state_ff != adc_types_pkg::ST_IDLE);
  assign sar.tracking = (state_ff == adc_types_pkg::ST_TRACK);
  assign sar.done     = (state_ff == adc_types_pkg::ST_FINISH);
  assign sar.code     = code_ff;

  // Checking helpers.
  logic [5:0] gap_ff;
  logic [2:0] trk_seen_ff;
  logic [3:0] conv_seen_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff == adc_types_pkg::ST_IDLE) begin
      gap_ff       <= 6'h00;
      trk_seen_ff  <= 3'h0;
      conv_seen_ff <= 4'h0;
    end else begin
      gap_ff       <= tick ? 6'h00 : gap_ff + 6'h01;
      trk_seen_ff  <= trk_seen_ff + 3'(tick && sar.tracking);
      conv_seen_ff <= conv_seen_ff +
                      4'(tick && state_ff == adc_types_pkg::ST_CONV);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_track_three;
    $fell(sar.tracking) && sar.enable |-> trk_seen_ff == 3'h3;
  endproperty
  a_track_three: assert property (p_track_three)
    else $error("tracking did not last three SAR clocks");

  property p_conv_ten;
    sar.done |-> conv_seen_ff == `CONV_SAR_CLKS;
  endproperty
  a_conv_ten: assert property (p_conv_ten)
    else $error("conversion did not take ten SAR clocks");

  property p_div_period;
    sar.busy && tick |-> gap_ff == {1'b0, div_lat_ff};
  endproperty
  a_div_period: assert property (p_div_period)
    else $error("SAR clock period does not match divider");

endmodule

// ==== rtl/sar_adc_ctrl.sv ====
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "adc_ctrl_cfg.svh"

// Function
// - Converter runs only while enabled.
// - Nine-way mux, eight inputs plus sensor.
// - Pairs single-ended or differential; reset single-ended.
// - Gain selectable 0.5 to 16, reset unity.
// - Sensor channel routed through programmed gain.
// - Ten-bit successive approximation after track-hold.
// - At most 100 ksps conversion rate.
// - SAR clock divided from system clock.
// - One start source chosen by mode bits.
// - Busy high during conversion, low after.
// - Busy falling sets done flag, interrupt.
// - Result left or right justified.
// - Track continuously when idle, normal mode.
// - Low-power mode tracks three SAR clocks first.
// - Strobe low-power: track low, convert rising.
// - No tracking during chip standby.
// - Start code map busy, T3, strobe, T2.
// - Gain code decode table.
// - SAR period is divider plus one.
module sar_adc_ctrl #(
  parameter int ADDR_W          = 8,
  parameter int MIN_CONV_CYCLES = `MIN_CONV_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              timer2_overflow,
  input  wire logic              timer3_overflow,
  input  wire logic              external_convert_strobe,
  input  wire logic              chip_standby,
  input  wire logic              comparator_out,
  output logic                   conv_unit_enable,
  output logic                   track_hold_sample,
  output logic [3:0]             channel_address_field,
  output logic                   mux_differential,
  output logic                   temp_sensor_select,
  output logic [2:0]             amp_gain_select,
  output logic [9:0]             sar_trial_code,
  output logic                   conv_irq
);

  localparam int HOLD_W = $clog2(MIN_CONV_CYCLES + 1);

  logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]        bresp_ff, rresp_ff;
  logic [7:0]        rdata_ff;
  logic              aw_got_ff, w_got_ff, wstrb0_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic [7:0]        wbyte_ff;
  logic              en_ff, tm_ff, done_ff, ljst_ff, irq_en_ff;
  logic [1:0]        src_ff;
  logic [7:0]        cfg_ff;
  logic [3:0]        pair_ff;
  logic [7:0]        res_hi_ff, res_lo_ff;
  logic              strobe_meta_ff, strobe_sync_ff, strobe_prev_ff;
  logic              comp_meta_ff, comp_sync_ff;
  logic [HOLD_W-1:0] holdoff_ff;
  logic              track_ff, diff_ff, temp_ff, irq_ff;
  logic [2:0]        gain_ff;
  logic [9:0]        trial_ff;
  logic [3:0]        chan_ff;

  sar_if sar ();

  sar_engine u_engine (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sar     (sar)
  );

  // Write channel: address and data are taken in either order.
  wire aw_take   = awvalid && awready_ff;
  wire w_take    = wvalid && wready_ff;
  wire wr_fire   = aw_got_ff && w_got_ff && !bvalid_ff;
  wire wr_en     = wr_fire && wstrb0_ff;
  wire wr_ctrl   = wr_en && waddr_ff == `OFS_CONTROL;
  wire wr_cfg    = wr_en && waddr_ff == `OFS_CONFIG;
  wire wr_chan   = wr_en && waddr_ff == `OFS_CHANNEL;
  wire wr_pair   = wr_en && waddr_ff == `OFS_PAIR_CFG;
  wire wr_irqen  = wr_en && waddr_ff == `OFS_IRQ_ENABLE;
  wire wr_hit    = waddr_ff == `OFS_CONTROL || waddr_ff == `OFS_CONFIG ||
                   waddr_ff == `OFS_CHANNEL || waddr_ff == `OFS_PAIR_CFG ||
                   waddr_ff == `OFS_RESULT_HI ||
                   waddr_ff == `OFS_RESULT_LO ||
                   waddr_ff == `OFS_IRQ_ENABLE;
  wire nxt_aw_got = (aw_got_ff || aw_take) && !wr_fire;
  wire nxt_w_got  = (w_got_ff || w_take) && !wr_fire;
  wire nxt_bvalid = wr_fire || (bvalid_ff && !bready);
  wire ar_take    = arvalid && arready_ff;
  wire nxt_rvalid = ar_take || (rvalid_ff && !rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b0;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      bvalid_ff  <= nxt_bvalid;
      awready_ff <= !nxt_aw_got && !nxt_bvalid;
      wready_ff  <= !nxt_w_got && !nxt_bvalid;
      rvalid_ff  <= nxt_rvalid;
      arready_ff <= !nxt_rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_ff  <= '0;
      wbyte_ff  <= 8'h00;
      wstrb0_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else begin
      if (aw_take) waddr_ff <= awaddr;
      if (w_take) wbyte_ff <= wdata[7:0];
      if (w_take) wstrb0_ff <= wstrb[0];
      if (wr_fire) bresp_ff <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // Read decode.
  wire [7:0] ctrl_rd = {en_ff, tm_ff, done_ff, sar.busy, src_ff, 1'b0,
                        ljst_ff};
  wire rd_hit = araddr == `OFS_CONTROL || araddr == `OFS_CONFIG ||
                araddr == `OFS_CHANNEL || araddr == `OFS_PAIR_CFG ||
                araddr == `OFS_RESULT_HI || araddr == `OFS_RESULT_LO ||
                araddr == `OFS_IRQ_ENABLE;
  wire [7:0] rd_byte =
    (araddr == `OFS_CONTROL)   ? ctrl_rd :
    (araddr == `OFS_CONFIG)    ? cfg_ff :
    (araddr == `OFS_CHANNEL)   ? {4'h0, chan_ff} :
    (araddr == `OFS_PAIR_CFG)  ? {4'h0, pair_ff} :
    (araddr == `OFS_RESULT_HI) ? res_hi_ff :
    (araddr == `OFS_RESULT_LO) ? res_lo_ff :
    (araddr == `OFS_IRQ_ENABLE) ? {7'h00, irq_en_ff} : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_ff <= 8'h00;
      rresp_ff <= `RESP_OKAY;
    end else if (ar_take) begin
      rdata_ff <= rd_byte;
      rresp_ff <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // Control and configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_ff     <= 1'b0;
      tm_ff     <= 1'b0;
      src_ff    <= `SRC_BUSY_WRITE;
      ljst_ff   <= 1'b0;
      cfg_ff    <= `CFG_RESET;
      chan_ff   <= `CHANNEL_RESET;
      pair_ff   <= `PAIR_RESET;
      irq_en_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        en_ff   <= wbyte_ff[`CTL_ENABLE_BIT];
        tm_ff   <= wbyte_ff[`CTL_LP_TRACK_BIT];
        src_ff  <= wbyte_ff[`CTL_SRC_HI_BIT:`CTL_SRC_LO_BIT];
        ljst_ff <= wbyte_ff[`CTL_LJUST_BIT];
      end
      if (wr_cfg) cfg_ff <= wbyte_ff;
      if (wr_chan) chan_ff <= wbyte_ff[3:0];
      if (wr_pair) pair_ff <= wbyte_ff[3:0];
      if (wr_irqen) irq_en_ff <= wbyte_ff[0];
    end
  end

  // Pins from outside the clock domain.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_meta_ff <= 1'b1;
      strobe_sync_ff <= 1'b1;
      strobe_prev_ff <= 1'b1;
      comp_meta_ff   <= 1'b0;
      comp_sync_ff   <= 1'b0;
    end else begin
      strobe_meta_ff <= external_convert_strobe;
      strobe_sync_ff <= strobe_meta_ff;
      strobe_prev_ff <= strobe_sync_ff;
      comp_meta_ff   <= comparator_out;
      comp_sync_ff   <= comp_meta_ff;
    end
  end

  // Start-of-conversion selection.
  wire sw_start    = wr_ctrl && wbyte_ff[`CTL_BUSY_BIT] &&
                     src_ff == `SRC_BUSY_WRITE;
  wire strobe_rise = strobe_sync_ff && !strobe_prev_ff;
  wire trigger     = (src_ff == `SRC_BUSY_WRITE) ? sw_start :
                     (src_ff == `SRC_TIMER3)     ? timer3_overflow :
                     (src_ff == `SRC_STROBE)     ? strobe_rise :
                                                   timer2_overflow;
  wire start_req   = trigger && en_ff && !sar.busy &&
                     holdoff_ff == '0;
  wire lp_strobe   = tm_ff && src_ff == `SRC_STROBE;

  assign sar.enable     = en_ff;
  assign sar.start      = start_req;
  assign sar.skip_track = !tm_ff || lp_strobe;
  assign sar.div        = cfg_ff[`CFG_DIV_MSB:`CFG_DIV_LSB];
  assign sar.comp_hi    = comp_sync_ff;

  // Back-to-back starts are spaced so the throughput cap holds.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      holdoff_ff <= '0;
    end else if (start_req) begin
      holdoff_ff <= HOLD_W'(MIN_CONV_CYCLES - 1);
    end else if (holdoff_ff != '0) begin
      holdoff_ff <= holdoff_ff - HOLD_W'(1);
    end
  end

  // Completion flag: a completion in the clearing cycle still sets it.
  wire nxt_done = sar.done ? 1'b1 :
                  wr_ctrl ? wbyte_ff[`CTL_DONE_BIT] : done_ff;

  // Result formatting.
  wire       is_temp = chan_ff[`TEMP_SENSOR_BIT];
  wire       is_diff = !is_temp && pair_ff[chan_ff[2:1]];
  wire [9:0] value   = is_diff ? {~sar.code[9], sar.code[8:0]} :
                                 sar.code;
  wire       sign    = is_diff && value[9];
  wire [15:0] res16  = ljst_ff ? {value, 6'h00} :
                                 {{6{sign}}, value};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_ff   <= 1'b0;
      res_hi_ff <= 8'h00;
      res_lo_ff <= 8'h00;
      irq_ff    <= 1'b0;
    end else begin
      done_ff <= nxt_done;
      irq_ff  <= nxt_done && irq_en_ff;
      if (sar.done) begin
        res_hi_ff <= res16[15:8];
        res_lo_ff <= res16[7:0];
      end
    end
  end

  // Track-and-hold and analog front-end controls.
  wire nxt_track = en_ff && !chip_standby &&
                   (sar.tracking ||
                    (!sar.busy && (!tm_ff ||
                     (lp_strobe && !strobe_sync_ff))));
  wire [2:0] gcode = cfg_ff[`CFG_GAIN_MSB:0];
  wire [2:0] gain_dec = gcode[2] ?
    (gcode[1] ? 3'(adc_types_pkg::GAIN_HALF) :
                3'(adc_types_pkg::GAIN_X16)) : gcode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      track_ff <= 1'b0;
      diff_ff  <= 1'b0;
      temp_ff  <= 1'b0;
      gain_ff  <= 3'(adc_types_pkg::GAIN_X1);
      trial_ff <= 10'h000;
    end else begin
      track_ff <= nxt_track;
      diff_ff  <= is_diff;
      temp_ff  <= is_temp;
      gain_ff  <= gain_dec;
      trial_ff <= sar.code;
    end
  end

  assign awready               = awready_ff;
  assign wready                = wready_ff;
  assign bvalid                = bvalid_ff;
  assign bresp                 = bresp_ff;
  assign arready               = arready_ff;
  assign rvalid                = rvalid_ff;
  assign rresp                 = rresp_ff;
  assign rdata                 = {24'h000000, rdata_ff};
  assign conv_unit_enable      = en_ff;
  assign track_hold_sample     = track_ff;
  assign channel_address_field = chan_ff;
  assign mux_differential      = diff_ff;
  assign temp_sensor_select    = temp_ff;
  assign amp_gain_select       = gain_ff;
  assign sar_trial_code        = trial_ff;
  assign conv_irq              = irq_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_off_idle;
    !en_ff |=> !sar.busy && !track_ff;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("converter active while disabled");

  property p_start_busy;
    start_req |=> sar.busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("accepted start did not raise busy");

  property p_no_restart;
    $rose(sar.busy) |-> $past(start_req);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("busy rose without an accepted start");

  property p_done_on_fall;
    $fell(sar.busy) && en_ff |-> done_ff ##1 (conv_irq == irq_en_ff);
  endproperty
  a_done_on_fall: assert property (p_done_on_fall)
    else $error("busy fell without setting done flag");

  property p_track_cont;
    en_ff && !tm_ff && !chip_standby && !sar.busy |=> track_ff;
  endproperty
  a_track_cont: assert property (p_track_cont)
    else $error("idle converter not tracking");

  property p_standby;
    chip_standby |=> !track_ff;
  endproperty
  a_standby: assert property (p_standby)
    else $error("tracking during standby");

  property p_left_just;
    sar.done && ljst_ff |=> res_lo_ff[5:0] == 6'h00;
  endproperty
  a_left_just: assert property (p_left_just)
    else $error("left justified result has low bits set");

  property p_gain_half;
    cfg_ff[2:1] == 2'b11 |=> amp_gain_select == 3'h5;
  endproperty
  a_gain_half: assert property (p_gain_half)
    else $error("gain code 11x did not select one half");

endmodule

// ==== tb/adc_far_side.sv ====
`timescale 1ns/100ps

// The analog level sits half a step above vin, so the search lands on vin.
module adc_far_side (
  input  wire logic [9:0] vin,
  input  wire logic [9:0] sar_trial_code,
  output logic            comparator_out
);
  assign comparator_out = (vin >= sar_trial_code);
endmodule

// ==== tb/tb_sar_adc_ctrl.sv ====
`timescale 1ns/100ps
`include "adc_ctrl_cfg.svh"

module tb_sar_adc_ctrl;
  typedef struct packed {
    logic        d;
    logic        l;
    logic [9:0]  v;
    logic [15:0] e;
  } row_s;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, standby = 0;
  logic [31:0] wdata = 0;
  logic [2:0]  trg = 0;
  logic [9:0]  vin = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        comp, en, th, diff, ts, irq;
  logic [1:0]  bresp, rresp, bq, rq;
  logic [31:0] rdata;
  logic [3:0]  chan;
  logic [2:0]  gain;
  logic [9:0]  trial;
  logic [7:0]  d, hi;
  int          n_mismatch = 0, num_checks = 0, n0, n;
  row_s        rows [5] = '{'{0, 0, 10'h2a5, 16'h02a5},
    '{0, 1, 10'h2a5, 16'ha940}, '{1, 0, 10'h0f0, 16'hfef0},
    '{1, 1, 10'h3ff, 16'h7fc0}, '{0, 0, 10'h000, 16'h0000}};

  sar_adc_ctrl #(.MIN_CONV_CYCLES(20)) sar_adc_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .timer2_overflow(trg[1]), .timer3_overflow(trg[0]),
    .external_convert_strobe(trg[2]), .chip_standby(standby),
    .comparator_out(comp), .conv_unit_enable(en), .track_hold_sample(th),
    .channel_address_field(chan), .mux_differential(diff),
    .temp_sensor_select(ts), .amp_gain_select(gain),
    .sar_trial_code(trial), .conv_irq(irq));

  adc_far_side adc_far_side_inst (
    .vin(vin), .sar_trial_code(trial), .comparator_out(comp));

  always #5 aclk = ~aclk;

  task chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wr(input logic [7:0] a, v);
    logic ta, tw;
    ta = 0;
    tw = 0;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        tw = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 0;
    bq = bresp;
    // One more edge so that outputs launched by the write have settled.
    @(posedge aclk);
  endtask

  task rd(input logic [7:0] a, output logic [7:0] v);
    araddr <= a;
    arvalid <= 1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 0;
    rready <= 1;
    @(posedge aclk);
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 0;
    v = rdata[7:0];
    rq = rresp;
  endtask

  // Counts cycles from one trigger pulse to the interrupt, 300 if none.
  task meas(input logic [7:0] cfg, ctl, input logic [2:0] t, output int c);
    wr(`OFS_CONFIG, cfg);
    wr(`OFS_CONTROL, ctl);
    repeat (25) @(posedge aclk);
    trg <= t;
    @(posedge aclk);
    trg <= 3'h0;
    c = 0;
    while (irq !== 1'b1 && c < 300) begin
      @(posedge aclk);
      c++;
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`OFS_CONFIG, d);
    chk(d, `CFG_RESET);
    rd(`OFS_PAIR_CFG, d);
    chk(d, `PAIR_RESET);
    chk(gain, 3'h0);
    chk(en, 0);
    $display("test reset done");
    wr(`OFS_CONFIG, 8'h18);
    wr(`OFS_IRQ_ENABLE, 8'h01);
    foreach (rows[i]) begin
      wr(`OFS_PAIR_CFG, {7'h0, rows[i].d});
      vin <= rows[i].v;
      wr(`OFS_CONTROL, {7'h40, rows[i].l});
      wr(`OFS_CONTROL, {7'h48, rows[i].l});
      rd(`OFS_CONTROL, d);
      chk(d[4], 1);
      n = 0;
      do begin
        rd(`OFS_CONTROL, d);
        n++;
      end while (d[5] !== 1'b1 && n < 100);
      chk(d[5], 1);
      chk(d[4], 0);
      rd(`OFS_RESULT_HI, hi);
      rd(`OFS_RESULT_LO, d);
      chk({hi, d}, rows[i].e);
    end
    chk(irq, 1);
    wr(`OFS_IRQ_ENABLE, 8'h00);
    chk(irq, 0);
    rd(`OFS_CONTROL, d);
    chk(d[5], 1);
    wr(`OFS_IRQ_ENABLE, 8'h01);
    $display("test table done");
    meas(8'h18, 8'h84, 3'b001, n0);
    chk(n0 < 300, 1);
    meas(8'h18, 8'hc4, 3'b001, n);
    chk(n - n0, 12);
    meas(8'h08, 8'h84, 3'b001, n);
    chk(n0 - n, 20);
    meas(8'h18, 8'h8c, 3'b010, n);
    chk(n, n0);
    meas(8'h18, 8'h84, 3'b010, n);
    chk(n, 300);
    // The strobe passes two synchroniser flops, so it starts two cycles late.
    meas(8'h18, 8'h88, 3'b100, n);
    chk(n, n0 + 2);
    meas(8'h18, 8'hc8, 3'b100, n);
    chk(n, n0 + 2);
    meas(8'h18, 8'h04, 3'b001, n);
    chk(n, 300);
    $display("test triggers done");
    for (int g = 0; g < 8; g++) begin
      wr(`OFS_CONFIG, 8'h18 | g[7:0]);
      chk(gain, g[2] ? {2'b10, g[1]} : g[2:0]);
    end
    wr(`OFS_CHANNEL, 8'h08);
    chk(ts, 1);
    chk(chan, 4'h8);
    wr(`OFS_PAIR_CFG, 8'h01);
    wr(`OFS_CHANNEL, 8'h01);
    chk(ts, 0);
    chk(diff, 1);
    rd(8'h1c, d);
    chk(rq, `RESP_SLVERR);
    wr(8'h1c, 8'hff);
    chk(bq, `RESP_SLVERR);
    wr(`OFS_CONTROL, 8'h80);
    chk(th, 1);
    standby <= 1;
    repeat (2) @(posedge aclk);
    chk(th, 0);
    standby <= 0;
    $display("test misc done");
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`OFS_CONFIG, d);
    chk(d, `CFG_RESET);
    chk({en, th, diff, gain}, 6'h00);
    $display("test reset again done");
    wrap_up();
  end
endmodule
